// [rtl/ppac_div.sv]
`timescale 1ns/1ns
`default_nettype none
module ppac_div
    import ppac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    ppac_div_if.div d
);
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic pulse;
    logic next_pulse;
    // ****************************************
    // count source ticks, divide by ratio plus one
    // ****************************************
    always_comb begin
        next_cnt = cnt;
        next_pulse = 1'b0;
        if (d.restart) begin
            next_cnt = 5'h00;
        end else if (!d.enable) begin
            next_cnt = cnt;
        end else if (cnt >= d.ratio) begin
            next_cnt = 5'h00;
            next_pulse = 1'b1;
        end else begin
            next_cnt = cnt + 5'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt <= 5'h00;
            pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            pulse <= next_pulse;
        end
    end
    assign d.clk_en = pulse;
    off_no_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        !d.enable |=> !pulse) else $error("divider pulsed while disabled");
    cover_div1_c: cover property (@(posedge sys_clk) d.enable && d.ratio == 5'h00 && pulse);
endmodule
`default_nettype wire

// [rtl/ppac_div_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface ppac_div_if;
    logic enable;
    logic [4:0] ratio;
    logic restart;
    logic clk_en;
    modport ctrl(output enable, output ratio, output restart, input clk_en);
    modport div(input enable, input ratio, input restart, output clk_en);
endinterface
`default_nettype wire

// [rtl/ppac_pkg.sv]
package ppac_pkg;
    // ****************************************
    // register map (byte offsets)
    // ****************************************
    localparam logic [7:0] OBS_DIV_OFS = 8'h00;
    localparam logic [7:0] POST_DIV_OFS = 8'h04;
    localparam logic [7:0] CMD_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;
    localparam logic [7:0] ALIGN_MASK_OFS = 8'h10;
    localparam logic [7:0] RATIO_CHG_OFS = 8'h14;
    localparam logic [7:0] RATIO_WR_OFS = 8'h18;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h1c;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int DIV_EN_BIT = 15;
    localparam int RATIO_W = 5;
    localparam int GO_BIT = 0;
    localparam int STABLE_BIT = 2;
    localparam int BUSY_BIT = 0;
    localparam int NCLK = 7;
    localparam logic [4:0] OBS_RATIO_RST = 5'h00;
    localparam logic [4:0] POST_RATIO_RST = 5'h01;
    localparam logic [6:0] ALIGN_MASK_RST = 7'h00;
    localparam logic [24:0] ALIGN_RSV_RST = 25'h0000003;
    // irq status bits: 0 go done, 1 osc stable
    localparam int IRQ_W = 2;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 40;
    localparam int OSC_STABLE_NS = 4000;
    localparam int OSC_STABLE_CYC = (OSC_STABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ALIGN_NS = 1280;
    localparam int ALIGN_CYC = (ALIGN_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {PPAC_IDLE, PPAC_WAIT, PPAC_ALIGN} ppac_state_t;
endpackage

// [rtl/ppac_top.sv]
// Notes on behaviour
// - observation divider runs only while its enable bit 15 is set
// - observation divider divides by ratio field plus one; zero passes through
// - observation clock is the selected source clock divided down
// - observation clock may be chosen to drive the clock output pin
// - post-divider applies only while its enable bit 15 is set
// - post-divider divides by ratio plus one; ratio resets to 1
// - writing 1 to go bit starts phase alignment of selected clocks
// - writing 0 to go bit clears it and changes nothing else
// - status bit 2 reads 1 once oscillator stable counter finished
// - stable counter must finish within the reset period; here it is held at zero during reset and counts only after release
// - status bit 0 reads 1 while alignment is in progress
// - align mask bits 0..6 select system clocks 1..7 for alignment
// - one ratio-changed flag per system clock
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module ppac_top
    import ppac_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic obs_src_clk_en,
    input wire logic obs_to_pin_sel,
    input wire logic alt_pin_clk_en,
    input wire logic pll_clk_en,
    output logic observation_clock,
    output logic clock_output_pin,
    output logic post_div_clk,
    output logic [6:0] align_restart,
    output logic irq
);
    // ****************************************
    // bus capture
    // ****************************************
    logic wr_pend;
    logic next_wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] next_wr_addr;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [31:0] rd_word;
    logic wr_go;
    // ****************************************
    // registers
    // ****************************************
    logic obs_en;
    logic [4:0] obs_ratio;
    logic post_en;
    logic [4:0] post_ratio;
    logic go_bit;
    logic [6:0] align_mask;
    logic [6:0] ratio_chg;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic next_obs_en;
    logic [4:0] next_obs_ratio;
    logic next_post_en;
    logic [4:0] next_post_ratio;
    logic next_go_bit;
    logic [6:0] next_align_mask;
    logic [6:0] next_ratio_chg;
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    // ****************************************
    // stable counter and align engine
    // ****************************************
    logic [15:0] osc_cnt;
    logic [15:0] next_osc_cnt;
    logic stable;
    logic next_stable;
    ppac_state_t state;
    ppac_state_t next_state;
    logic [15:0] al_cnt;
    logic [15:0] next_al_cnt;
    logic busy;
    logic busy_q;
    logic stable_q;
    logic obs_q;
    logic next_obs_q;
    logic post_q;
    logic next_post_q;
    logic go_start;
    logic [6:0] restart_q;
    logic [6:0] next_restart_q;

    ppac_div_if obs_if();
    ppac_div_if post_if();

    assign wr_go = wr_pend && wr_addr == CMD_OFS && hwdata[GO_BIT];
    assign go_start = wr_go && state == PPAC_IDLE;
    assign busy = state != PPAC_IDLE;

    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            OBS_DIV_OFS: rd_word = {16'h0000, obs_en, 10'h000, obs_ratio};
            POST_DIV_OFS: rd_word = {16'h0000, post_en, 10'h000, post_ratio};
            CMD_OFS: rd_word = {31'h0, go_bit};
            STATUS_OFS: rd_word = {29'h0, stable, 1'b0, busy};
            ALIGN_MASK_OFS: rd_word = {ALIGN_RSV_RST, align_mask};
            RATIO_CHG_OFS: rd_word = {25'h0, ratio_chg};
            IRQ_STAT_OFS: rd_word = {30'h0, irq_stat};
            IRQ_MASK_OFS: rd_word = {30'h0, irq_mask};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_wr_pend = hsel && hready && htrans[1] && hwrite;
        next_wr_addr = hsel && hready && htrans[1] ? haddr[7:0] : wr_addr;
        next_rdata = rdata;
        if (hsel && hready && htrans[1] && !hwrite) begin
            next_rdata = rd_word;
        end
    end

    always_comb begin
        next_obs_en = obs_en;
        next_obs_ratio = obs_ratio;
        next_post_en = post_en;
        next_post_ratio = post_ratio;
        next_go_bit = go_bit;
        next_align_mask = align_mask;
        next_ratio_chg = ratio_chg;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (wr_pend) begin
            case (wr_addr)
                OBS_DIV_OFS: begin
                    next_obs_en = hwdata[DIV_EN_BIT];
                    next_obs_ratio = hwdata[RATIO_W-1:0];
                end
                POST_DIV_OFS: begin
                    next_post_en = hwdata[DIV_EN_BIT];
                    next_post_ratio = hwdata[RATIO_W-1:0];
                end
                CMD_OFS: next_go_bit = hwdata[GO_BIT];
                ALIGN_MASK_OFS: next_align_mask = hwdata[NCLK-1:0];
                RATIO_WR_OFS: next_ratio_chg = ratio_chg | hwdata[NCLK-1:0];
                IRQ_STAT_OFS: next_irq_stat = irq_stat & ~hwdata[IRQ_W-1:0];
                IRQ_MASK_OFS: next_irq_mask = hwdata[IRQ_W-1:0];
                default: next_go_bit = go_bit;
            endcase
        end
        if (state == PPAC_ALIGN && al_cnt == 16'h0000) begin
            next_go_bit = 1'b0;
            next_ratio_chg = ratio_chg & ~align_mask;
        end
        if (busy_q && !busy) begin
            next_irq_stat[0] = 1'b1;
        end
        if (stable && !stable_q) begin
            next_irq_stat[1] = 1'b1;
        end
    end

    always_comb begin
        next_osc_cnt = osc_cnt;
        next_stable = stable;
        if (osc_cnt == 16'(OSC_STABLE_CYC - 1)) begin
            next_stable = 1'b1;
        end else begin
            next_osc_cnt = osc_cnt + 16'h0001;
        end
        next_state = state;
        next_al_cnt = al_cnt;
        next_restart_q = 7'h00;
        case (state)
            PPAC_IDLE: begin
                if (go_start) begin
                    next_state = PPAC_WAIT;
                end
            end
            PPAC_WAIT: begin
                if (stable) begin
                    next_state = PPAC_ALIGN;
                    next_al_cnt = 16'(ALIGN_CYC - 1);
                    next_restart_q = align_mask;
                end
            end
            PPAC_ALIGN: begin
                if (al_cnt == 16'h0000) begin
                    next_state = PPAC_IDLE;
                end else begin
                    next_al_cnt = al_cnt - 16'h0001;
                end
            end
            default: next_state = PPAC_IDLE;
        endcase
        next_obs_q = obs_if.clk_en;
        next_post_q = post_if.clk_en;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            rdata <= 32'h0000_0000;
            obs_en <= 1'b0;
            obs_ratio <= OBS_RATIO_RST;
            post_en <= 1'b0;
            post_ratio <= POST_RATIO_RST;
            go_bit <= 1'b0;
            align_mask <= ALIGN_MASK_RST;
            ratio_chg <= 7'h00;
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            osc_cnt <= 16'h0000;
            stable <= 1'b0;
            state <= PPAC_IDLE;
            al_cnt <= 16'h0000;
            busy_q <= 1'b0;
            stable_q <= 1'b0;
            obs_q <= 1'b0;
            post_q <= 1'b0;
            restart_q <= 7'h00;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            rdata <= next_rdata;
            obs_en <= next_obs_en;
            obs_ratio <= next_obs_ratio;
            post_en <= next_post_en;
            post_ratio <= next_post_ratio;
            go_bit <= next_go_bit;
            align_mask <= next_align_mask;
            ratio_chg <= next_ratio_chg;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            osc_cnt <= next_osc_cnt;
            stable <= next_stable;
            state <= next_state;
            al_cnt <= next_al_cnt;
            busy_q <= busy;
            stable_q <= stable;
            obs_q <= next_obs_q;
            post_q <= next_post_q;
            restart_q <= next_restart_q;
        end
    end

    // ****************************************
    // dividers and outputs
    // ****************************************
    assign obs_if.enable = obs_en && obs_src_clk_en;
    assign obs_if.ratio = obs_ratio;
    assign obs_if.restart = !obs_en;
    assign post_if.enable = post_en && pll_clk_en;
    assign post_if.ratio = post_ratio;
    assign post_if.restart = !post_en;

    ppac_div u_obs_div (.sys_clk(sys_clk), .rst(rst), .d(obs_if));
    ppac_div u_post_div (.sys_clk(sys_clk), .rst(rst), .d(post_if));

    assign observation_clock = obs_q;
    assign clock_output_pin = obs_to_pin_sel ? obs_q : alt_pin_clk_en;
    assign post_div_clk = post_q;
    assign align_restart = restart_q;
    assign irq = |(irq_stat & irq_mask);
    assign hrdata = rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ****************************************
    // checks
    // ****************************************
    go_starts_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
        go_start |=> busy) else $error("go did not start alignment");
    zero_no_effect_a: assert property (@(posedge sys_clk) disable iff (rst)
        wr_pend && wr_addr == CMD_OFS && !hwdata[GO_BIT] && !busy |=> !busy)
        else $error("writing zero started alignment");
    stable_time_a: assert property (@(posedge sys_clk) disable iff (rst)
        osc_cnt == 16'(OSC_STABLE_CYC - 1) |=> stable) else $error("stable late");
    stable_holds_a: assert property (@(posedge sys_clk) disable iff (rst)
        stable |=> stable) else $error("stable dropped");
    busy_ends_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == PPAC_ALIGN && $past(state) == PPAC_WAIT |-> ##[1:40] !busy)
        else $error("alignment never ended");
    restart_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == PPAC_WAIT && stable |=> restart_q == $past(align_mask))
        else $error("restart not from mask");
    chg_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        state == PPAC_ALIGN && al_cnt == 16'h0000 |=> (ratio_chg & $past(align_mask)) == 7'h00)
        else $error("changed flags not cleared");
    status_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
        busy |-> rd_word[BUSY_BIT] || haddr[7:0] != STATUS_OFS) else $error("busy misread");
    pin_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        obs_to_pin_sel |-> clock_output_pin == observation_clock) else $error("pin mux");
    cover_go_c: cover property (@(posedge sys_clk) go_start ##[1:60] !busy);
    cover_irq_c: cover property (@(posedge sys_clk) irq);
    cover_obs_c: cover property (@(posedge sys_clk) observation_clock);
endmodule
`default_nettype wire

// [tb/pll_post_divider_ctrl_phase_align_ctrl_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module pll_post_divider_ctrl_phase_align_ctrl_tb_top
    import ppac_pkg::*;
;
    localparam logic [31:0] EN = 32'h00000001 << DIV_EN_BIT;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic obs_src_clk_en = 1'b0;
    logic obs_to_pin_sel = 1'b1;
    logic alt_pin_clk_en = 1'b0;
    logic pll_clk_en = 1'b0;
    logic observation_clock;
    logic clock_output_pin;
    logic post_div_clk;
    logic [6:0] align_restart;
    logic irq;
    logic src_half = 1'b0;
    logic [31:0] rd;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int rel = 0;

    assign hready = hreadyout;

    ppac_top i_ppac_top (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .obs_src_clk_en(obs_src_clk_en), .obs_to_pin_sel(obs_to_pin_sel),
        .alt_pin_clk_en(alt_pin_clk_en), .pll_clk_en(pll_clk_en),
        .observation_clock(observation_clock), .clock_output_pin(clock_output_pin),
        .post_div_clk(post_div_clk), .align_restart(align_restart), .irq(irq));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // source ticks: every cycle, or every other cycle for a slower source
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        obs_src_clk_en <= src_half ? ~obs_src_clk_en : 1'b1;
        pll_clk_en <= 1'b1;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task results;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            compares++;
            if (seen !== exp) begin
                fails++;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task wait_ready;
        int n;
        begin
            n = 0;
            @(posedge sys_clk);
            while (hready !== 1'b1) begin
                n++;
                if (n > 50) begin
                    fails++;
                    results();
                end
                @(posedge sys_clk);
            end
        end
    endtask

    // one single word transfer: address phase, then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        begin
            @(posedge sys_clk);
            hsel <= 1'b1;
            haddr <= {24'h000000, a};
            htrans <= 2'h2;
            hwrite <= w;
            wait_ready();
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            wait_ready();
            rd = hrdata;
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        begin
            bus(1'b1, a, d);
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        begin
            bus(1'b0, a, 32'h00000000);
            check(rd, exp);
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        begin
            rdchk(STATUS_OFS, 32'h00000000);
            check({hreadyout, hresp}, 32'h00000002);
            rdchk(OBS_DIV_OFS, 32'h00000000);
            rdchk(POST_DIV_OFS, 32'h00000001);
            rdchk(CMD_OFS, 32'h00000000);
            rdchk(ALIGN_MASK_OFS, 32'h00000180);
            rdchk(RATIO_CHG_OFS, 32'h00000000);
            wr(8'h24, 32'hffffffff);
            rdchk(8'h24, 32'h00000000);
            while (cyc < rel + OSC_STABLE_CYC - 12)
                @(posedge sys_clk);
            rdchk(STATUS_OFS, 32'h00000000);
            while (cyc < rel + OSC_STABLE_CYC + 6)
                @(posedge sys_clk);
            rdchk(STATUS_OFS, 32'h00000004);
            rdchk(IRQ_STAT_OFS, 32'h00000002);
            @(negedge sys_clk);
            check(irq, 1'b0);
        end
    endtask

    task run_case(input logic [31:0] ov, input logic [31:0] pv, input logic sel,
                  input logic half, input int eo, input int ep, input int ed);
        int no;
        int np;
        int nd;
        begin
            wr(OBS_DIV_OFS, ov);
            wr(POST_DIV_OFS, pv);
            obs_to_pin_sel <= sel;
            alt_pin_clk_en <= ~sel;
            src_half <= half;
            repeat (20) @(posedge sys_clk);
            no = 0;
            np = 0;
            nd = 0;
            repeat (60) begin
                @(negedge sys_clk);
                no += (observation_clock === 1'b1);
                np += (clock_output_pin === 1'b1);
                nd += (post_div_clk === 1'b1);
            end
            check(no, eo);
            check(np, ep);
            check(nd, ed);
            rdchk(OBS_DIV_OFS, ov);
        end
    endtask

    task t_div;
        begin
            run_case(32'h00000000, 32'h00000001, 1'b1, 1'b0, 0, 0, 0);
            run_case(EN, EN | 32'h00000001, 1'b1, 1'b0, 60, 60, 30);
            run_case(EN | 32'h00000002, EN | 32'h00000004, 1'b1, 1'b0, 20, 20, 12);
            run_case(EN | 32'h00000002, 32'h00000004, 1'b0, 1'b1, 10, 60, 0);
            rdchk(POST_DIV_OFS, 32'h00000004);
        end
    endtask

    task t_go;
        int n;
        int t0;
        begin
            wr(IRQ_MASK_OFS, 32'h00000001);
            wr(ALIGN_MASK_OFS, 32'h00000055);
            rdchk(ALIGN_MASK_OFS, 32'h000001d5);
            wr(RATIO_WR_OFS, 32'h0000007f);
            rdchk(RATIO_CHG_OFS, 32'h0000007f);
            wr(CMD_OFS, 32'h00000001);
            n = 0;
            @(negedge sys_clk);
            while (align_restart === 7'h00) begin
                n++;
                if (n > 40) begin
                    fails++;
                    results();
                end
                @(negedge sys_clk);
            end
            t0 = cyc;
            check(align_restart, 7'h55);
            rdchk(STATUS_OFS, 32'h00000005);
            rdchk(CMD_OFS, 32'h00000001);
            wr(CMD_OFS, 32'h00000000);
            rdchk(CMD_OFS, 32'h00000000);
            rdchk(STATUS_OFS, 32'h00000005);
            n = 0;
            rd = 32'h00000001;
            // no further change until alignment finishes
            while (rd[BUSY_BIT] !== 1'b0) begin
                n++;
                if (n > 40) begin
                    fails++;
                    results();
                end
                bus(1'b0, STATUS_OFS, 32'h00000000);
            end
            check(rd, 32'h00000004);
            check(cyc - t0 >= ALIGN_CYC - 4 && cyc - t0 <= ALIGN_CYC + 8, 1'b1);
            rdchk(CMD_OFS, 32'h00000000);
            rdchk(RATIO_CHG_OFS, 32'h0000002a);
            @(negedge sys_clk);
            check(irq, 1'b1);
            rdchk(IRQ_STAT_OFS, 32'h00000003);
            wr(IRQ_STAT_OFS, 32'h00000001);
            rdchk(IRQ_STAT_OFS, 32'h00000002);
            @(negedge sys_clk);
            check(irq, 1'b0);
        end
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rel = cyc;
        t_reset();
        t_div();
        t_go();
        results();
    end
endmodule
`default_nettype wire
